// ### rtl/fdiag_top.sv
// Purpose: transaction decoder for the flash overlay spaces (ecc, link crc, integrity crc, boot config)
// Assumes: one decoded transaction per txn_valid pulse; array read data valid while arr_req is high
// Notes: apb slave with one wait state; sticky events gated onto irq by the mask
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "fdiag_consts.svh"

module fdiag_top #(
   parameter int AW = 24,
   parameter int HP_AW = 4,
   parameter int HP_SHIFT = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host transaction port
   input wire logic txn_valid,
   input wire fdiag_pkg::fdiag_op_t txn_op,
   input wire logic [AW-1:0] txn_addr,
   input wire logic [15:0] txn_wdata,
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   // memory array read port
   output logic arr_req,
   output logic [AW-1:0] arr_addr,
   input wire logic [15:0] arr_rdata,
   // correction events and link crc feed
   input wire logic ecc_evt,
   input wire logic ecc_evt_fail,
   input wire logic [31:0] ecc_evt_addr,
   input wire logic lcrc_upd,
   input wire logic [31:0] lcrc_val,
   // boot configuration out
   output logic [31:0] boot_cfg,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   // interrupt
   output logic irq
);

   localparam int HP_N = 1 << HP_AW;

   typedef struct packed {
      fdiag_pkg::fdiag_ov_t ov;
      fdiag_pkg::fdiag_eng_t eng;
      logic [HP_N-1:0][1:0] hps;
      logic [31:0] trap;
      logic [15:0] cnt;
      logic [31:0] lcrc;
      logic [31:0] icrc;
      logic [AW-1:0] start_a;
      logic [AW-1:0] end_a;
      logic [AW-1:0] cur_a;
      logic [31:0] boot;
      logic arr_req;
      logic arr_eng;
      logic [AW-1:0] arr_addr;
      logic rsp_valid;
      logic [15:0] rsp_data;
      logic [`FDIAG_EV_W-1:0] sts;
      logic [`FDIAG_EV_W-1:0] mask;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } fdiag_state_t;

   fdiag_state_t st_ff;
   fdiag_state_t nxt_st;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // crc32 step over one 16-bit array word, msb first
   function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [15:0] d);
      logic [31:0] c;
      c = crc;
      for (int i = 15; i >= 0; i--) begin
         if (c[31] ^ d[i]) begin
            c = {c[30:0], 1'b0} ^ `FDIAG_CRC_POLY;
         end else begin
            c = {c[30:0], 1'b0};
         end
      end
      return c;
   endfunction : crc_step

   // transaction set of each overlay
   function automatic logic op_legal(input fdiag_pkg::fdiag_ov_t ov, input fdiag_pkg::fdiag_eng_t eng,
                                     input fdiag_pkg::fdiag_op_t op);
      logic ok;
      ok = 1'b0;
      unique case (ov)
         fdiag_pkg::OV_NONE: begin
            ok = op inside {fdiag_pkg::OP_ARRAY_READ, fdiag_pkg::OP_ECC_ENTRY, fdiag_pkg::OP_LCRC_ENTRY,
                            fdiag_pkg::OP_INT_ENTRY, fdiag_pkg::OP_BOOT_ENTRY};
         end
         fdiag_pkg::OV_ECC: begin
            ok = op inside {fdiag_pkg::OP_ECC_STATUS_READ, fdiag_pkg::OP_TRAP_LOW_READ, fdiag_pkg::OP_EXIT,
                            fdiag_pkg::OP_TRAP_HIGH_READ, fdiag_pkg::OP_COUNT_READ, fdiag_pkg::OP_ECC_CLEAR};
         end
         fdiag_pkg::OV_LCRC: begin
            ok = op inside {fdiag_pkg::OP_LCRC_READ, fdiag_pkg::OP_EXIT};
         end
         fdiag_pkg::OV_INT: begin
            ok = op inside {fdiag_pkg::OP_INT_START_LOAD, fdiag_pkg::OP_INT_END_LOAD, fdiag_pkg::OP_INT_SUSPEND,
                            fdiag_pkg::OP_INT_RESUME, fdiag_pkg::OP_INT_LOW_READ, fdiag_pkg::OP_INT_HIGH_READ,
                            fdiag_pkg::OP_EXIT}
                 || (op == fdiag_pkg::OP_SUSP_ARRAY_READ && eng == fdiag_pkg::ENG_SUSP);
         end
         fdiag_pkg::OV_BOOT: begin
            ok = op inside {fdiag_pkg::OP_BOOT_PROGRAM, fdiag_pkg::OP_BOOT_READ, fdiag_pkg::OP_EXIT};
         end
         default: begin
            ok = 1'b0;
         end
      endcase
      return ok;
   endfunction : op_legal

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb begin
      logic take;
      logic arr_busy;
      logic apb_hit;
      logic [`FDIAG_EV_W-1:0] ev;
      logic [`FDIAG_EV_W-1:0] w1c;
      logic [HP_AW-1:0] hp_txn;
      logic [HP_AW-1:0] hp_evt;
      take = 1'b0;
      arr_busy = 1'b0;
      apb_hit = psel && penable && st_ff.pready;
      ev = '0;
      w1c = '0;
      hp_txn = txn_addr[HP_SHIFT +: HP_AW];
      hp_evt = ecc_evt_addr[HP_SHIFT +: HP_AW];
      nxt_st = st_ff;
      nxt_st.rsp_valid = 1'b0;
      nxt_st.arr_req = 1'b0;

      // array read completion, data valid while arr_req is high
      if (st_ff.arr_req && !st_ff.arr_eng) begin
         nxt_st.rsp_valid = 1'b1;
         nxt_st.rsp_data = arr_rdata;
      end
      if (st_ff.arr_req && st_ff.arr_eng) begin
         nxt_st.icrc = crc_step(st_ff.icrc, arr_rdata);
         if (st_ff.cur_a == st_ff.end_a) begin
            nxt_st.eng = fdiag_pkg::ENG_DONE;
            ev[`FDIAG_EV_INT_DONE] = 1'b1;
         end else begin
            nxt_st.cur_a = st_ff.cur_a + AW'(1);
         end
      end

      // host transaction decode
      // an offer while the port is busy is refused, host retries on bad_txn
      if (txn_valid) begin
         if (!op_legal(st_ff.ov, st_ff.eng, txn_op) || st_ff.arr_req) begin
            ev[`FDIAG_EV_BAD_TXN] = 1'b1;
         end else begin
            take = 1'b1;
         end
      end
      if (take) begin
         unique case (txn_op)
            fdiag_pkg::OP_ARRAY_READ, fdiag_pkg::OP_SUSP_ARRAY_READ: begin
               nxt_st.arr_req = 1'b1;
               nxt_st.arr_eng = 1'b0;
               nxt_st.arr_addr = txn_addr;
               arr_busy = 1'b1;
            end
            fdiag_pkg::OP_ECC_ENTRY: begin
               nxt_st.ov = fdiag_pkg::OV_ECC;
            end
            fdiag_pkg::OP_LCRC_ENTRY: begin
               nxt_st.ov = fdiag_pkg::OV_LCRC;
            end
            fdiag_pkg::OP_INT_ENTRY: begin
               nxt_st.ov = fdiag_pkg::OV_INT;
            end
            fdiag_pkg::OP_BOOT_ENTRY: begin
               nxt_st.ov = fdiag_pkg::OV_BOOT;
            end
            fdiag_pkg::OP_ECC_STATUS_READ: begin
               nxt_st.rsp_valid = 1'b1;
               nxt_st.rsp_data = {14'h0000, st_ff.hps[hp_txn]};
            end
            fdiag_pkg::OP_TRAP_LOW_READ: begin
               nxt_st.rsp_valid = 1'b1;
               nxt_st.rsp_data = st_ff.trap[15:0];
            end
            fdiag_pkg::OP_TRAP_HIGH_READ: begin
               nxt_st.rsp_valid = 1'b1;
               nxt_st.rsp_data = st_ff.trap[31:16];
            end
            fdiag_pkg::OP_COUNT_READ: begin
               nxt_st.rsp_valid = 1'b1;
               nxt_st.rsp_data = st_ff.cnt;
            end
            fdiag_pkg::OP_ECC_CLEAR: begin
               nxt_st.hps = '0;
               w1c[`FDIAG_EV_ECC_FAIL] = 1'b1;
            end
            fdiag_pkg::OP_EXIT: begin
               nxt_st.ov = fdiag_pkg::OV_NONE;
               if (st_ff.ov == fdiag_pkg::OV_LCRC) begin
                  nxt_st.lcrc = `FDIAG_LCRC_INIT;
               end
            end
            fdiag_pkg::OP_LCRC_READ: begin
               nxt_st.rsp_valid = 1'b1;
               nxt_st.rsp_data = (txn_addr[0] == `FDIAG_HALF_HIGH) ? st_ff.lcrc[31:16] : st_ff.lcrc[15:0];
            end
            fdiag_pkg::OP_INT_START_LOAD: begin
               nxt_st.start_a = txn_addr;
            end
            fdiag_pkg::OP_INT_END_LOAD: begin
               nxt_st.end_a = txn_addr;
               nxt_st.cur_a = st_ff.start_a;
               nxt_st.icrc = `FDIAG_ICRC_INIT;
               nxt_st.eng = fdiag_pkg::ENG_RUN;
            end
            fdiag_pkg::OP_INT_SUSPEND: begin
               if (nxt_st.eng == fdiag_pkg::ENG_RUN) begin
                  nxt_st.eng = fdiag_pkg::ENG_SUSP;
               end
            end
            fdiag_pkg::OP_INT_RESUME: begin
               if (st_ff.eng == fdiag_pkg::ENG_SUSP) begin
                  nxt_st.eng = fdiag_pkg::ENG_RUN;
               end
            end
            fdiag_pkg::OP_INT_LOW_READ: begin
               nxt_st.rsp_valid = 1'b1;
               nxt_st.rsp_data = st_ff.icrc[15:0];
            end
            fdiag_pkg::OP_INT_HIGH_READ: begin
               nxt_st.rsp_valid = 1'b1;
               nxt_st.rsp_data = st_ff.icrc[31:16];
            end
            fdiag_pkg::OP_BOOT_PROGRAM: begin
               if (txn_addr[0] == `FDIAG_HALF_HIGH) begin
                  nxt_st.boot[31:16] = txn_wdata;
               end else begin
                  nxt_st.boot[15:0] = txn_wdata;
               end
            end
            fdiag_pkg::OP_BOOT_READ: begin
               nxt_st.rsp_valid = 1'b1;
               nxt_st.rsp_data = (txn_addr[0] == `FDIAG_HALF_HIGH) ? st_ff.boot[31:16] : st_ff.boot[15:0];
            end
            default: begin
               nxt_st.rsp_valid = 1'b0;
            end
         endcase
      end

      // engine issues one array read when the port is free and not suspended
      // a host array read claims the port first, the engine waits two cycles
      if (nxt_st.eng == fdiag_pkg::ENG_RUN && !arr_busy && !st_ff.arr_req) begin
         nxt_st.arr_req = 1'b1;
         nxt_st.arr_eng = 1'b1;
         nxt_st.arr_addr = nxt_st.cur_a;
      end

      // link crc value follows its feed, a same-cycle update beats the exit clear
      if (lcrc_upd) begin
         nxt_st.lcrc = lcrc_val;
      end

      // correction events: trap address, count, half-page status
      if (ecc_evt) begin
         nxt_st.trap = ecc_evt_addr;
         if (st_ff.cnt != `FDIAG_CNT_MAX) begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
         end
         nxt_st.hps[hp_evt][`FDIAG_HPS_CORR] = 1'b1;
         if (ecc_evt_fail) begin
            nxt_st.hps[hp_evt][`FDIAG_HPS_FAIL] = 1'b1;
            ev[`FDIAG_EV_ECC_FAIL] = 1'b1;
         end
      end

      // apb: one wait state, effect at the edge where pready is seen high
      // prdata and pslverr hold through the pready cycle
      nxt_st.pready = psel && penable && !st_ff.pready;
      nxt_st.pslverr = 1'b0;
      if (psel && penable && !st_ff.pready) begin
         nxt_st.prdata = 32'h0000_0000;
         unique case (paddr)
            `FDIAG_OFS_STATUS: nxt_st.prdata = {29'h0, st_ff.sts};
            `FDIAG_OFS_MASK: nxt_st.prdata = {29'h0, st_ff.mask};
            `FDIAG_OFS_MODE: nxt_st.prdata = {27'h0, st_ff.eng, st_ff.ov};
            `FDIAG_OFS_ICRC: nxt_st.prdata = st_ff.icrc;
            `FDIAG_OFS_BOOT: nxt_st.prdata = st_ff.boot;
            default: nxt_st.pslverr = 1'b1;
         endcase
      end
      if (apb_hit && pwrite) begin
         if (paddr == `FDIAG_OFS_STATUS) begin
            w1c = w1c | pwdata[`FDIAG_EV_W-1:0];
         end
         if (paddr == `FDIAG_OFS_MASK) begin
            nxt_st.mask = pwdata[`FDIAG_EV_W-1:0];
         end
      end

      // sticky status, a new event wins over its clear
      nxt_st.sts = (st_ff.sts & ~w1c) | ev;
      nxt_st.irq = |(nxt_st.sts & nxt_st.mask);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
         st_ff.ov <= fdiag_pkg::OV_NONE;
         st_ff.eng <= fdiag_pkg::ENG_IDLE;
         st_ff.lcrc <= `FDIAG_LCRC_INIT;
         st_ff.icrc <= `FDIAG_ICRC_INIT;
         st_ff.boot <= `FDIAG_BOOT_RST;
         st_ff.mask <= `FDIAG_MASK_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register

   assign rsp_valid = st_ff.rsp_valid;
   assign rsp_data = st_ff.rsp_data;
   assign arr_req = st_ff.arr_req;
   assign arr_addr = st_ff.arr_addr;
   assign boot_cfg = st_ff.boot;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign prdata = st_ff.prdata;
   assign irq = st_ff.irq;

endmodule : fdiag_top

// ### rtl/fdiag_consts.svh
// Purpose: offsets, field positions, reset values and codes of the overlay diagnostics block
// Assumes: included by bare name from the top module, the checker and the bench
// Notes: offsets, field positions, reset values and limits live here as macros; HP_AW and HP_SHIFT are fdiag_top parameters
`ifndef FDIAG_CONSTS_SVH
`define FDIAG_CONSTS_SVH

// apb register byte offsets
`define FDIAG_OFS_STATUS 8'h00
`define FDIAG_OFS_MASK 8'h04
`define FDIAG_OFS_MODE 8'h08
`define FDIAG_OFS_ICRC 8'h0c
`define FDIAG_OFS_BOOT 8'h10

// status and mask bit positions
`define FDIAG_EV_ECC_FAIL 0
`define FDIAG_EV_INT_DONE 1
`define FDIAG_EV_BAD_TXN 2
`define FDIAG_EV_W 3

// half-page status word fields
`define FDIAG_HPS_CORR 0
`define FDIAG_HPS_FAIL 1

// reset and initial values, crc polynomial and count limit
`define FDIAG_LCRC_INIT 32'h0000_0000
`define FDIAG_ICRC_INIT 32'hffff_ffff
`define FDIAG_CRC_POLY 32'h04c1_1db7
`define FDIAG_BOOT_RST 32'h0000_0000
`define FDIAG_MASK_RST 3'h0
`define FDIAG_CNT_MAX 16'hffff

// overlay word addresses for split 32-bit values
`define FDIAG_HALF_LOW 1'h0
`define FDIAG_HALF_HIGH 1'h1

`endif

// ### rtl/fdiag_pkg.sv
// Purpose: types shared by the overlay diagnostics block and its bench
// Assumes: constants come from fdiag_consts.svh
// Notes: transaction kinds are driven by the host side as fdiag_pkg::fdiag_op_t
package fdiag_pkg;

   // transaction kinds, one per decoded host transaction
   typedef enum logic [4:0] {
      OP_ARRAY_READ,
      OP_ECC_ENTRY,
      OP_ECC_STATUS_READ,
      OP_TRAP_LOW_READ,
      OP_TRAP_HIGH_READ,
      OP_COUNT_READ,
      OP_ECC_CLEAR,
      OP_EXIT,
      OP_LCRC_ENTRY,
      OP_LCRC_READ,
      OP_INT_ENTRY,
      OP_INT_START_LOAD,
      OP_INT_END_LOAD,
      OP_INT_SUSPEND,
      OP_SUSP_ARRAY_READ,
      OP_INT_RESUME,
      OP_INT_LOW_READ,
      OP_INT_HIGH_READ,
      OP_BOOT_ENTRY,
      OP_BOOT_PROGRAM,
      OP_BOOT_READ
   } fdiag_op_t;

   // overlay currently entered
   typedef enum logic [2:0] {
      OV_NONE,
      OV_ECC,
      OV_LCRC,
      OV_INT,
      OV_BOOT
   } fdiag_ov_t;

   // data-integrity engine state
   typedef enum logic [1:0] {
      ENG_IDLE,
      ENG_RUN,
      ENG_SUSP,
      ENG_DONE
   } fdiag_eng_t;

endpackage : fdiag_pkg

// ### verification/fdiag_chk_sva.sv
// Purpose: port-level checks of the overlay diagnostics block
// Assumes: one clock domain, async active-high reset
// Notes: mirrors overlay, trap address and correction count from the ports
`timescale 1ns/1ns
`include "fdiag_consts.svh"

module fdiag_chk #(
   parameter int AW = 24
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host transaction port
   input wire logic txn_valid,
   input wire fdiag_pkg::fdiag_op_t txn_op,
   input wire logic [AW-1:0] txn_addr,
   input wire logic [15:0] txn_wdata,
   input wire logic rsp_valid,
   input wire logic [15:0] rsp_data,
   // array port, events, boot value
   input wire logic arr_req,
   input wire logic [AW-1:0] arr_addr,
   input wire logic [15:0] arr_rdata,
   input wire logic ecc_evt,
   input wire logic [31:0] ecc_evt_addr,
   input wire logic [31:0] boot_cfg,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr
);
   fdiag_pkg::fdiag_ov_t ov_ff;
   logic [31:0] trap_ff;
   logic [15:0] cnt_ff;
   logic tk;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // a transaction is taken only while the array port is free
   assign tk = txn_valid && !arr_req;
   // mirror of entered overlay and correction bookkeeping
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ov_ff <= fdiag_pkg::OV_NONE;
         trap_ff <= 32'h0;
         cnt_ff <= 16'h0;
      end else begin
         if (ecc_evt) begin
            trap_ff <= ecc_evt_addr;
            cnt_ff <= (cnt_ff == `FDIAG_CNT_MAX) ? cnt_ff : cnt_ff + 16'h1;
         end
         if (tk && txn_op == fdiag_pkg::OP_EXIT) begin
            ov_ff <= fdiag_pkg::OV_NONE;
         end else if (tk && ov_ff == fdiag_pkg::OV_NONE) begin
            case (txn_op)
               fdiag_pkg::OP_ECC_ENTRY: ov_ff <= fdiag_pkg::OV_ECC;
               fdiag_pkg::OP_LCRC_ENTRY: ov_ff <= fdiag_pkg::OV_LCRC;
               fdiag_pkg::OP_INT_ENTRY: ov_ff <= fdiag_pkg::OV_INT;
               fdiag_pkg::OP_BOOT_ENTRY: ov_ff <= fdiag_pkg::OV_BOOT;
               default: ;
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   a_trap_words:
   assert property (tk && ov_ff == fdiag_pkg::OV_ECC && !ecc_evt && cnt_ff != 16'h0 &&
      txn_op inside {fdiag_pkg::OP_TRAP_LOW_READ, fdiag_pkg::OP_TRAP_HIGH_READ} |=> rsp_valid &&
      rsp_data == ($past(txn_op) == fdiag_pkg::OP_TRAP_LOW_READ ? trap_ff[15:0] : trap_ff[31:16]))
      else $error("trap word read wrong");
   a_count_read:
   assert property (tk && ov_ff == fdiag_pkg::OV_ECC && !ecc_evt && txn_op == fdiag_pkg::OP_COUNT_READ
      |=> rsp_valid && rsp_data == cnt_ff) else $error("correction count read wrong");
   a_lcrc_answer:
   assert property (tk && ov_ff == fdiag_pkg::OV_LCRC && txn_op == fdiag_pkg::OP_LCRC_READ |=> rsp_valid)
      else $error("link crc read unanswered");
   a_boot_read:
   assert property (tk && ov_ff == fdiag_pkg::OV_BOOT && txn_op == fdiag_pkg::OP_BOOT_READ |=> rsp_valid &&
      rsp_data == ($past(txn_addr[0]) ? boot_cfg[31:16] : boot_cfg[15:0])) else $error("boot read wrong");
   a_boot_program:
   assert property (tk && ov_ff == fdiag_pkg::OV_BOOT && txn_op == fdiag_pkg::OP_BOOT_PROGRAM
      |=> ($past(txn_addr[0]) ? boot_cfg[31:16] : boot_cfg[15:0]) == $past(txn_wdata))
      else $error("boot program not stored");
   a_array_data:
   assert property (rsp_valid && $past(arr_req) |-> rsp_data == $past(arr_rdata))
      else $error("array data not returned");
   a_array_req:
   assert property (tk && ov_ff == fdiag_pkg::OV_NONE && txn_op == fdiag_pkg::OP_ARRAY_READ
      |=> arr_req && arr_addr == $past(txn_addr) ##1 rsp_valid) else $error("array read not issued");
   a_wrong_set:
   assert property (tk && ov_ff != fdiag_pkg::OV_ECC && txn_op == fdiag_pkg::OP_ECC_STATUS_READ |=> !rsp_valid)
      else $error("op outside overlay answered");
   a_apb_wait:
   assert property (psel && penable && !pready |=> pready) else $error("apb wait state wrong");
   a_apb_unmapped:
   assert property (psel && penable && pready && paddr > `FDIAG_OFS_BOOT |-> pslverr)
      else $error("unmapped apb access not flagged");
   // main scenarios reached
   cover property (tk && txn_op == fdiag_pkg::OP_INT_SUSPEND);
   cover property (rsp_valid && $past(arr_req));
   cover property (psel && penable && pready && pslverr);
endmodule : fdiag_chk

bind fdiag_top fdiag_chk #(.AW(AW)) fdiag_chk_i (.clk, .rst, .txn_valid, .txn_op, .txn_addr, .txn_wdata,
   .rsp_valid, .rsp_data, .arr_req, .arr_addr, .arr_rdata, .ecc_evt, .ecc_evt_addr, .boot_cfg,
   .psel, .penable, .paddr, .pready, .pslverr);

// ### verification/fdiag_array_model.sv
// Purpose: memory array behind the block's array read port
// Assumes: data is a fixed function of the word address
// Notes: data is valid only while requested
`timescale 1ns/1ns

module fdiag_array_model (
   // clock and array port
   input wire logic clk,
   input wire logic arr_req,
   input wire logic [23:0] arr_addr,
   output logic [15:0] arr_rdata
);
   logic [15:0] last_ff = 16'h0;
   // keep last word so an idle port shows its inverse, not stale data
   always_ff @(posedge clk) begin
      if (arr_req) last_ff <= arr_rdata;
   end
   assign arr_rdata = arr_req ? (arr_addr[15:0] ^ 16'h6b3d) : ~last_ff;
endmodule : fdiag_array_model

// ### verification/fdiag_bench.sv
// Purpose: self-checking bench of the overlay diagnostics block
// Assumes: host transactions and apb driven at the rising edge
// Notes: txn offers are held while the array port is busy
`timescale 1ns/1ns
`include "fdiag_consts.svh"

module fdiag_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic txn_valid = 1'b0;
   fdiag_pkg::fdiag_op_t txn_op = fdiag_pkg::OP_ARRAY_READ;
   logic [23:0] txn_addr = 24'h0;
   logic [15:0] txn_wdata = 16'h0;
   logic ecc_evt = 1'b0;
   logic ecc_evt_fail = 1'b0;
   logic [31:0] ecc_evt_addr = 32'h0;
   logic lcrc_upd = 1'b0;
   logic [31:0] lcrc_val = 32'h0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic rsp_valid, arr_req, pready, pslverr, irq, erv;
   logic [15:0] rsp_data, arr_rdata;
   logic [23:0] arr_addr;
   logic [31:0] boot_cfg, prdata, rdv, crc;
   int n_errors = 0;
   int total_checks = 0;
   int k;

   always #4 clk = ~clk;

   fdiag_top fdiag_top_i (.clk, .rst, .txn_valid, .txn_op, .txn_addr, .txn_wdata, .rsp_valid, .rsp_data,
      .arr_req, .arr_addr, .arr_rdata, .ecc_evt, .ecc_evt_fail, .ecc_evt_addr, .lcrc_upd, .lcrc_val,
      .boot_cfg, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .irq);
   fdiag_array_model fdiag_array_model_i (.clk, .arr_req, .arr_addr, .arr_rdata);

   ////////////////////////////////////////////////////////////////
   // expected array word and integrity value
   function automatic logic [15:0] mdata(input logic [23:0] a);
      return a[15:0] ^ 16'h6b3d;
   endfunction : mdata
   function automatic logic [31:0] crc_of(input logic [23:0] s, input logic [23:0] e);
      logic [31:0] c;
      logic [15:0] w;
      c = `FDIAG_ICRC_INIT;
      for (logic [23:0] a = s; a <= e; a++) begin
         w = mdata(a);
         for (int i = 15; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i]) ? `FDIAG_CRC_POLY : 32'h0);
      end
      return c;
   endfunction : crc_of

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // one host transaction, re-offered while the array port is busy
   task automatic txn(input fdiag_pkg::fdiag_op_t op, input logic [23:0] a, input logic [15:0] d);
      @(posedge clk);
      txn_valid <= 1'b1;
      txn_op <= op;
      txn_addr <= a;
      txn_wdata <= d;
      do @(negedge clk); while (arr_req === 1'b1);
      @(posedge clk);
      txn_valid <= 1'b0;
   endtask : txn

   task automatic rd(input fdiag_pkg::fdiag_op_t op, input logic [23:0] a, input logic [15:0] exp);
      int n;
      txn(op, a, 16'h0);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 4);
      chk("rsp", {15'h0, rsp_valid, rsp_data}, {16'h1, exp});
   endtask : rd

   task automatic nrd(input fdiag_pkg::fdiag_op_t op, input logic [23:0] a);
      logic r;
      txn(op, a, 16'h0);
      r = 1'b0;
      repeat (3) begin
         @(negedge clk);
         r = r | rsp_valid;
      end
      chk("no_rsp", {31'h0, r}, 32'h0);
   endtask : nrd

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // wait for the slave as long as it takes, only the watchdog ends this
      do @(negedge clk); while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic ar(input logic [7:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h0);
      chk("apb_rd", rdv, exp);
      chk("apb_err", {31'h0, erv}, {31'h0, e});
   endtask : ar

   task automatic ecc(input logic [31:0] a, input logic f);
      @(posedge clk);
      ecc_evt <= 1'b1;
      ecc_evt_fail <= f;
      ecc_evt_addr <= a;
      @(posedge clk);
      ecc_evt <= 1'b0;
   endtask : ecc

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   ////////////////////////////////////////////////////////////////
   // watchdog
   initial begin
      #400000;
      n_errors++;
      $display("ERROR watchdog expected done seen hang");
      tally_and_finish();
   end

   // test sequence
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd(fdiag_pkg::OP_ARRAY_READ, 24'h000123, mdata(24'h000123));
      ar(`FDIAG_OFS_MASK, 32'h0, 1'b0);
      ar(8'h14, 32'h0, 1'b1);
      $display("test apb done");
      ecc(32'h0000_0030, 1'b0);
      ecc(32'h1234_0050, 1'b1);
      ar(`FDIAG_OFS_STATUS, 32'h1, 1'b0);
      apb(1'b1, `FDIAG_OFS_MASK, 32'h1);
      repeat (2) @(negedge clk);
      chk("irq", {31'h0, irq}, 32'h1);
      txn(fdiag_pkg::OP_ECC_ENTRY, 24'h0, 16'h0);
      rd(fdiag_pkg::OP_ECC_STATUS_READ, 24'h00003a, 16'h0001);
      rd(fdiag_pkg::OP_ECC_STATUS_READ, 24'h000045, 16'h0000);
      rd(fdiag_pkg::OP_ECC_STATUS_READ, 24'h00005e, 16'h0003);
      rd(fdiag_pkg::OP_TRAP_LOW_READ, 24'h0, 16'h0050);
      rd(fdiag_pkg::OP_TRAP_HIGH_READ, 24'h0, 16'h1234);
      rd(fdiag_pkg::OP_COUNT_READ, 24'h0, 16'h0002);
      txn(fdiag_pkg::OP_ECC_CLEAR, 24'h0, 16'h0);
      rd(fdiag_pkg::OP_ECC_STATUS_READ, 24'h000031, 16'h0000);
      chk("irq", {31'h0, irq}, 32'h0);
      ar(`FDIAG_OFS_STATUS, 32'h0, 1'b0);
      txn(fdiag_pkg::OP_EXIT, 24'h0, 16'h0);
      rd(fdiag_pkg::OP_ARRAY_READ, 24'h000077, mdata(24'h000077));
      $display("test ecc done");
      @(posedge clk);
      lcrc_upd <= 1'b1;
      lcrc_val <= 32'hcafe_f00d;
      @(posedge clk);
      lcrc_upd <= 1'b0;
      txn(fdiag_pkg::OP_LCRC_ENTRY, 24'h0, 16'h0);
      rd(fdiag_pkg::OP_LCRC_READ, 24'h0, 16'hf00d);
      rd(fdiag_pkg::OP_LCRC_READ, 24'h1, 16'hcafe);
      txn(fdiag_pkg::OP_EXIT, 24'h0, 16'h0);
      txn(fdiag_pkg::OP_LCRC_ENTRY, 24'h0, 16'h0);
      rd(fdiag_pkg::OP_LCRC_READ, 24'h1, 16'h0000);
      txn(fdiag_pkg::OP_EXIT, 24'h0, 16'h0);
      $display("test link crc done");
      txn(fdiag_pkg::OP_BOOT_ENTRY, 24'h3f0000, 16'h0);
      txn(fdiag_pkg::OP_BOOT_PROGRAM, 24'h0, 16'ha5c3);
      txn(fdiag_pkg::OP_BOOT_PROGRAM, 24'h1, 16'h0f1e);
      rd(fdiag_pkg::OP_BOOT_READ, 24'h0, 16'ha5c3);
      rd(fdiag_pkg::OP_BOOT_READ, 24'h1, 16'h0f1e);
      chk("boot_cfg", boot_cfg, 32'h0f1e_a5c3);
      ar(`FDIAG_OFS_BOOT, 32'h0f1e_a5c3, 1'b0);
      nrd(fdiag_pkg::OP_ECC_STATUS_READ, 24'h0);
      ar(`FDIAG_OFS_STATUS, 32'h4, 1'b0);
      apb(1'b1, `FDIAG_OFS_STATUS, 32'h4);
      ar(`FDIAG_OFS_STATUS, 32'h0, 1'b0);
      txn(fdiag_pkg::OP_EXIT, 24'h0, 16'h0);
      $display("test boot done");
      crc = crc_of(24'h000010, 24'h00001f);
      txn(fdiag_pkg::OP_INT_ENTRY, 24'h0, 16'h0);
      txn(fdiag_pkg::OP_INT_START_LOAD, 24'h000010, 16'h0);
      txn(fdiag_pkg::OP_INT_END_LOAD, 24'h00001f, 16'h0);
      txn(fdiag_pkg::OP_INT_SUSPEND, 24'h0, 16'h0);
      ar(`FDIAG_OFS_MODE, 32'h13, 1'b0);
      rd(fdiag_pkg::OP_SUSP_ARRAY_READ, 24'h000200, mdata(24'h000200));
      txn(fdiag_pkg::OP_INT_RESUME, 24'h0, 16'h0);
      ar(`FDIAG_OFS_MODE, 32'h0b, 1'b0);
      nrd(fdiag_pkg::OP_ARRAY_READ, 24'h000020);
      k = 0;
      do begin
         apb(1'b0, `FDIAG_OFS_STATUS, 32'h0);
         k++;
      end while (rdv[1] !== 1'b1 && k < 60);
      chk("int_done", {31'h0, rdv[1]}, 32'h1);
      rd(fdiag_pkg::OP_INT_LOW_READ, 24'h0, crc[15:0]);
      rd(fdiag_pkg::OP_INT_HIGH_READ, 24'h0, crc[31:16]);
      txn(fdiag_pkg::OP_EXIT, 24'h0, 16'h0);
      $display("test integrity done");
      tally_and_finish();
   end
endmodule : fdiag_bench
